// File: tb/irq_host_model.sv
// host side model that watches the alarm pin and times its low pulses
`timescale 1ns/1ps
module irq_host_model
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic irq_n_i,
  output int pulse_count_o,
  output int low_width_o
);
  int run_ff;
  // a held-low alarm also counts once it is released
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      run_ff <= 0;
      pulse_count_o <= 0;
      low_width_o <= 0;
    end
    else if (!irq_n_i)
      run_ff <= run_ff + 1;
    else if (run_ff != 0)
    begin
      pulse_count_o <= pulse_count_o + 1;
      low_width_o <= run_ff;
      run_ff <= 0;
    end
  end
endmodule

// File: tb/rtc_alarm_trim_bench.sv
// register-level bench for the alarm and trim block
`timescale 1ns/1ps
`include "rtc_alarm_params.svh"
module rtc_alarm_trim_bench;
  localparam int PLEN = 8;
  logic clk = 0;
  logic reset_n = 0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 0;
  logic rd_done = 0;
  logic tick_in = 0;
  logic [7:0] tm [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03};
  logic on_bat = 0;
  logic fout = 0;
  logic [7:0] rdata;
  logic irq_n;
  logic flag;
  logic [6:0] cap1;
  logic [6:0] cap2;
  logic [6:0] capl;
  int exp_cx;
  logic signed [7:0] ppm;
  int failures = 0;
  int n_checks = 0;
  int pulses;
  int width;
  int p0;
  int ppm_tab [8] = '{0, 20, 40, 60, 0, -20, -40, -60};
  int bat_ofs [4] = '{0, -1, 1, 2};
  logic [5:0] codes [5] = '{6'h00, 6'h10, 6'h1f, 6'h20, 6'h3f};

  rtc_alarm_trim #(.PULSE_LEN(PLEN)) u_dut
  (
    .clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_en), .reg_rd_done_i(rd_done),
    .sec_tick_i(tick_in), .time_sec_i(tm[0]), .time_min_i(tm[1]),
    .time_hour_i(tm[2]), .time_date_i(tm[3]), .time_month_i(tm[4]),
    .time_wday_i(tm[5]), .on_battery_i(on_bat), .fout_i(fout),
    .reg_rdata_o(rdata), .irq_fout_o(irq_n), .alarm_flag_o(flag),
    .cap_x1_half_pf_o(cap1), .cap_x2_half_pf_o(cap2),
    .cap_load_qtr_pf_o(capl), .rate_trim_ppm_o(ppm)
  );

  irq_host_model u_host
  (
    .clk_i(clk), .reset_n_i(reset_n), .irq_n_i(irq_n),
    .pulse_count_o(pulses), .low_width_o(width)
  );

  initial
  begin
    forever #4 clk = ~clk;
  end

  task finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check(input string name, input logic [7:0] seen,
             input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1;
    @(negedge clk);
    wr_en = 0;
    @(negedge clk);
  endtask

  task rd(input logic [4:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    check("rdata", rdata, exp);
  endtask

  // time bytes settle before the tick edge, as a real counter would
  task tick(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
    @(negedge clk);
    tm[0] = s;
    tm[1] = m;
    tm[2] = h;
    @(negedge clk);
    tick_in = 1;
    repeat (10) @(negedge clk);
    tick_in = 0;
    repeat (20) @(negedge clk);
  endtask

  task pins(input logic f, input logic i);
    check("alarm_flag", {7'h00, flag}, {7'h00, f});
    check("irq_pin", {7'h00, irq_n}, {7'h00, i});
  endtask

  initial
  begin
    #160000;
    failures++;
    finish_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset_n = 1;
    pins(0, 1);
    check("cap_load", {1'b0, capl}, 8'd50);
    check("ppm", ppm, 8'h00);
    rd(`ADDR_STATUS, 8'h00);
    $display("test reset done");
    foreach (codes[i])
    begin
      exp_cx = 32 * !codes[i][5] + codes[i][4:0] + 18;
      wr(`ADDR_LOAD_CAP, {2'b00, codes[i]});
      rd(`ADDR_LOAD_CAP, {2'b00, codes[i]});
      check("cap_x1", {1'b0, cap1}, 8'(exp_cx));
      check("cap_x2", {1'b0, cap2}, 8'(exp_cx));
      check("cap_load", {1'b0, capl}, 8'(exp_cx));
    end
    on_bat = 1;
    for (int f = 0; f < 4; f++)
    begin
      wr(`ADDR_LOAD_CAP, {f[1:0], 6'h00});
      repeat (4) @(negedge clk);
      check("cap_bat", {1'b0, cap1}, 8'(50 + bat_ofs[f]));
      check("cap_bat_load", {1'b0, capl}, 8'(50 + bat_ofs[f]));
    end
    on_bat = 0;
    repeat (4) @(negedge clk);
    check("cap_mains", {1'b0, cap1}, 8'd50);
    for (int i = 0; i < 8; i++)
    begin
      wr(`ADDR_RATE_TRIM, 8'(i));
      check("ppm", ppm, 8'(ppm_tab[i]));
    end
    $display("test trim done");
    for (int a = 8'h0c; a <= 8'h13; a++)
    begin
      wr(5'(a), 8'h5a ^ 8'(a));
      rd(5'(a), 8'h5a ^ 8'(a));
    end
    wr(5'h1f, 8'hff);
    rd(5'h1f, 8'h00);
    wr(5'h09, 8'hff);
    rd(5'h09, 8'h00);
    $display("test registers done");
    for (int a = 8'h0c; a <= 8'h11; a++)
      wr(5'(a), 8'h00);
    wr(`ADDR_ALARM_FIRST, 8'hb0);
    wr(5'h0d, 8'h45);
    wr(`ADDR_INT_CTRL, 8'h40);
    tick(8'h29, 8'h10, 8'h11);
    pins(0, 1);
    tick(8'h30, 8'h10, 8'h11);
    pins(1, 0);
    rd(`ADDR_STATUS, 8'h04);
    tick(8'h31, 8'h10, 8'h11);
    pins(1, 0);
    wr(`ADDR_STATUS, 8'h04);
    pins(1, 0);
    wr(`ADDR_STATUS, 8'h00);
    repeat (20) @(negedge clk);
    pins(0, 1);
    wr(5'h0d, 8'h90);
    wr(5'h0e, 8'h92);
    tick(8'h30, 8'h10, 8'h11);
    pins(0, 1);
    tick(8'h30, 8'h10, 8'h12);
    pins(1, 0);
    wr(`ADDR_INT_CTRL, 8'h00);
    pins(1, 1);
    $display("test single done");
    wr(`ADDR_STATUS, 8'h80);
    wr(`ADDR_INT_CTRL, 8'h40);
    tick(8'h30, 8'h10, 8'h12);
    rd(`ADDR_STATUS, 8'h84);
    @(negedge clk);
    rd_done = 1;
    @(negedge clk);
    rd_done = 0;
    repeat (2) @(negedge clk);
    pins(0, 1);
    rd(`ADDR_STATUS, 8'h80);
    wr(`ADDR_STATUS, 8'h00);
    $display("test auto clear done");
    wr(`ADDR_INT_CTRL, 8'hc0);
    p0 = pulses;
    tick(8'h30, 8'h10, 8'h12);
    check("pulses", 8'(pulses - p0), 8'd1);
    check("width", 8'(width), 8'(PLEN));
    pins(1, 1);
    tick(8'h30, 8'h10, 8'h12);
    check("pulses", 8'(pulses - p0), 8'd2);
    $display("test pulse done");
    wr(`ADDR_STATUS, 8'h00);
    wr(`ADDR_INT_CTRL, 8'h41);
    repeat (3) @(negedge clk);
    check("fout_lo", {7'h00, irq_n}, 8'h00);
    fout = 1;
    tick(8'h30, 8'h10, 8'h12);
    pins(0, 1);
    $display("test fout done");
    finish_test();
  end
endmodule

// File: verilog/alarm_cmp_if.sv
// carrier between the register file and the alarm comparator
`timescale 1ns/1ps
interface alarm_cmp_if;
  logic [7:0] alarm_byte [6];
  logic [7:0] time_byte [6];
  logic match;
  modport owner (output alarm_byte, output time_byte, input match);
  modport cmp (input alarm_byte, input time_byte, output match);
endinterface

// File: verilog/alarm_compare.sv
// per-byte masked comparison of alarm against calendar bytes
`timescale 1ns/1ps
`include "rtc_alarm_params.svh"
module alarm_compare
(
  alarm_cmp_if.cmp bus
);
  logic [`ALARM_BYTES-1:0] hit;
  logic [`ALARM_BYTES-1:0] used;
  genvar g;
  generate
    for (g = 0; g < `ALARM_BYTES; g++)
    begin : gen_byte
      assign used[g] = bus.alarm_byte[g][`MATCH_EN_BIT];
      assign hit[g] = !used[g] ||
        (bus.alarm_byte[g][6:0] == bus.time_byte[g][6:0]);
    end
  endgenerate
  // no byte enabled never matches; year is simply not among the bytes
  assign bus.match = (&hit) && (|used);
endmodule

// File: verilog/rtc_alarm_params.svh
// register map, field positions and timing constants for the alarm block
`ifndef RTC_ALARM_PARAMS_SVH
`define RTC_ALARM_PARAMS_SVH
`define ADDR_STATUS 5'h07
`define ADDR_INT_CTRL 5'h08
`define ADDR_LOAD_CAP 5'h0a
`define ADDR_RATE_TRIM 5'h0b
`define ADDR_ALARM_FIRST 5'h0c
`define ADDR_ALARM_LAST 5'h11
`define ADDR_USER0 5'h12
`define ADDR_USER1 5'h13
`define ST_AUTO_CLEAR 7
`define ST_ALARM_FLAG 2
`define INT_PULSE_MODE 7
`define INT_ALARM_EN 6
`define BAT_OFS_LSB 6
`define MATCH_EN_BIT 7
`define ALARM_BYTES 6
`define PULSE_MS 250
`define CLK_KHZ 125000
`define PULSE_CYCLES (`PULSE_MS * `CLK_KHZ)
`define CNT_W 25
`define TRIM_NONE 3'h4
`define FOUT_SEL_MSB 3
`define CX_BASE 7'h12
`define CAP_MID 7'h32
`endif

// File: verilog/rtc_alarm_pkg.sv
// shared types for the alarm and trim block
package rtc_alarm_pkg;
  typedef enum logic [1:0]
  {
    IRQ_IDLE = 2'b00,
    IRQ_HELD = 2'b01,
    IRQ_PULSE = 2'b10
  } irq_state_type;
endpackage

// File: verilog/rtc_alarm_trim.sv
// alarm, interrupt pin, trim decode and user bytes of the clock
`timescale 1ns/1ps
`include "rtc_alarm_params.svh"
module rtc_alarm_trim
#(
  parameter int PULSE_LEN = `PULSE_CYCLES
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_done_i,
  input wire logic sec_tick_i,
  input wire logic [7:0] time_sec_i,
  input wire logic [7:0] time_min_i,
  input wire logic [7:0] time_hour_i,
  input wire logic [7:0] time_date_i,
  input wire logic [7:0] time_month_i,
  input wire logic [7:0] time_wday_i,
  input wire logic on_battery_i,
  input wire logic fout_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_fout_o,
  output logic alarm_flag_o,
  output logic [6:0] cap_x1_half_pf_o,
  output logic [6:0] cap_x2_half_pf_o,
  output logic [6:0] cap_load_qtr_pf_o,
  output logic signed [7:0] rate_trim_ppm_o
);
  logic [7:0] alarm_ff [`ALARM_BYTES];
  logic [7:0] int_ctrl_ff;
  logic [7:0] load_cap_ff;
  logic [2:0] rate_trim_ff;
  logic [7:0] user0_ff;
  logic [7:0] user1_ff;
  logic auto_clear_ff;
  logic alarm_flag_ff;
  logic tick_sync1_ff;
  logic tick_sync2_ff;
  logic tick_prev_ff;
  logic bat_sync1_ff;
  logic bat_sync2_ff;
  logic [1:0] eval_dly_ff;
  logic [`CNT_W-1:0] pulse_cnt_ff;
  rtc_alarm_pkg::irq_state_type irq_state_ff;
  rtc_alarm_pkg::irq_state_type nxt_irq_state;
  logic match;
  logic alarm_event;
  logic alarm_en;
  logic pulse_mode;
  logic fout_sel;
  logic flag_clr;
  logic [6:0] cx_half;
  logic [6:0] cx_bat;
  logic [7:0] nxt_rdata;
  alarm_cmp_if cmp_bus ();
  default clocking dflt_cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  function automatic logic is_alarm_addr(input logic [4:0] a);
    is_alarm_addr = (a >= `ADDR_ALARM_FIRST) && (a <= `ADDR_ALARM_LAST);
  endfunction
  function automatic logic [2:0] alarm_idx(input logic [4:0] a);
    logic [4:0] d;
    d = a - `ADDR_ALARM_FIRST;
    alarm_idx = d[2:0];
  endfunction
  assign alarm_en = int_ctrl_ff[`INT_ALARM_EN];
  assign pulse_mode = int_ctrl_ff[`INT_PULSE_MODE];
  assign fout_sel = |int_ctrl_ff[`FOUT_SEL_MSB:0];
  // register writes
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      int_ctrl_ff <= 8'h00;
      load_cap_ff <= 8'h00;
      rate_trim_ff <= 3'h0;
      auto_clear_ff <= 1'b0;
      for (int i = 0; i < `ALARM_BYTES; i++)
        alarm_ff[i] <= 8'h00;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `ADDR_STATUS)
        auto_clear_ff <= reg_wdata_i[`ST_AUTO_CLEAR];
      if (reg_addr_i == `ADDR_INT_CTRL)
        int_ctrl_ff <= reg_wdata_i;
      if (reg_addr_i == `ADDR_LOAD_CAP)
        load_cap_ff <= reg_wdata_i;
      if (reg_addr_i == `ADDR_RATE_TRIM)
        rate_trim_ff <= reg_wdata_i[2:0];
      if (is_alarm_addr(reg_addr_i))
        alarm_ff[alarm_idx(reg_addr_i)] <= reg_wdata_i;
    end
  end
  // user bytes survive only through the supply, so reset leaves zero
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      user0_ff <= 8'h00;
      user1_ff <= 8'h00;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `ADDR_USER0)
        user0_ff <= reg_wdata_i;
      if (reg_addr_i == `ADDR_USER1)
        user1_ff <= reg_wdata_i;
    end
  end
  // tick and battery come from another domain
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tick_sync1_ff <= 1'b0;
      tick_sync2_ff <= 1'b0;
      tick_prev_ff <= 1'b0;
      bat_sync1_ff <= 1'b0;
      bat_sync2_ff <= 1'b0;
    end
    else
    begin
      tick_sync1_ff <= sec_tick_i;
      tick_sync2_ff <= tick_sync1_ff;
      tick_prev_ff <= tick_sync2_ff;
      bat_sync1_ff <= on_battery_i;
      bat_sync2_ff <= bat_sync1_ff;
    end
  end
  // wait two cycles after the tick so the time bytes have settled
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      eval_dly_ff <= 2'b00;
    else
      eval_dly_ff <= {eval_dly_ff[0], tick_sync2_ff & ~tick_prev_ff};
  end
  generate
    for (genvar g = 0; g < `ALARM_BYTES; g++)
    begin : gen_alarm_bus
      assign cmp_bus.alarm_byte[g] = alarm_ff[g];
    end
  endgenerate
  assign cmp_bus.time_byte[0] = time_sec_i;
  assign cmp_bus.time_byte[1] = time_min_i;
  assign cmp_bus.time_byte[2] = time_hour_i;
  assign cmp_bus.time_byte[3] = time_date_i;
  assign cmp_bus.time_byte[4] = time_month_i;
  assign cmp_bus.time_byte[5] = time_wday_i;
  assign match = cmp_bus.match;
  alarm_compare u_cmp
  (
    .bus(cmp_bus)
  );
  // frequency output disables the alarm function
  assign alarm_event = eval_dly_ff[1] && match && alarm_en && !fout_sel;
  // a zero written to the flag bit clears it, as does a finished status read while auto clear is set
  assign flag_clr = (reg_wr_i && reg_addr_i == `ADDR_STATUS &&
    !reg_wdata_i[`ST_ALARM_FLAG]) ||
    (reg_rd_done_i && reg_addr_i == `ADDR_STATUS && auto_clear_ff);
  // set wins over clear, so a match during a read stays visible
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alarm_flag_ff <= 1'b0;
    else if (alarm_event)
      alarm_flag_ff <= 1'b1;
    else if (flag_clr)
      alarm_flag_ff <= 1'b0;
  end
  always_comb
  begin
    nxt_irq_state = irq_state_ff;
    case (irq_state_ff)
      rtc_alarm_pkg::IRQ_IDLE:
        if (alarm_event)
          nxt_irq_state = pulse_mode ? rtc_alarm_pkg::IRQ_PULSE
                                     : rtc_alarm_pkg::IRQ_HELD;
      rtc_alarm_pkg::IRQ_HELD:
        if (!alarm_flag_ff || pulse_mode)
          nxt_irq_state = rtc_alarm_pkg::IRQ_IDLE;
      rtc_alarm_pkg::IRQ_PULSE:
        if (pulse_cnt_ff == `CNT_W'(PULSE_LEN - 1))
          nxt_irq_state = rtc_alarm_pkg::IRQ_IDLE;
      default:
        nxt_irq_state = rtc_alarm_pkg::IRQ_IDLE;
    endcase
    if (!alarm_en || fout_sel)
      nxt_irq_state = rtc_alarm_pkg::IRQ_IDLE;
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_state_ff <= rtc_alarm_pkg::IRQ_IDLE;
    else
      irq_state_ff <= nxt_irq_state;
  end
  // pulse timing ignores the flag entirely
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pulse_cnt_ff <= '0;
    else if (irq_state_ff == rtc_alarm_pkg::IRQ_PULSE)
      pulse_cnt_ff <= pulse_cnt_ff + `CNT_W'(1);
    else
      pulse_cnt_ff <= '0;
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_fout_o <= 1'b1;
    else if (fout_sel)
      irq_fout_o <= fout_i;
    else
      irq_fout_o <= (nxt_irq_state == rtc_alarm_pkg::IRQ_IDLE);
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alarm_flag_o <= 1'b0;
    else
      alarm_flag_o <= alarm_flag_ff;
  end
  // capacitance in half picofarads: 16,8,4,2,1,0.5 weights plus 9
  assign cx_half = `CX_BASE + {1'b0, ~load_cap_ff[5], load_cap_ff[4:0]};
  always_comb
  begin
    cx_bat = cx_half;
    if (bat_sync2_ff)
      case (load_cap_ff[`BAT_OFS_LSB+1:`BAT_OFS_LSB])
        2'b01: cx_bat = cx_half - 7'd1;
        2'b10: cx_bat = cx_half + 7'd1;
        2'b11: cx_bat = cx_half + 7'd2;
        default: cx_bat = cx_half;
      endcase
  end
  // x1 and x2 share one code; load value equals cx in quarter units
  // seven bits: the top code plus battery offset reaches 83 half pF
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cap_x1_half_pf_o <= `CAP_MID;
      cap_x2_half_pf_o <= `CAP_MID;
      cap_load_qtr_pf_o <= `CAP_MID;
    end
    else
    begin
      cap_x1_half_pf_o <= cx_bat;
      cap_x2_half_pf_o <= cx_bat;
      cap_load_qtr_pf_o <= cx_bat;
    end
  end
  // signed ppm handed to the second counter
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rate_trim_ppm_o <= 8'sh00;
    else if (rate_trim_ff[2])
      rate_trim_ppm_o <= -$signed({1'b0, rate_trim_ff[1], rate_trim_ff[0],
        2'b00} * 8'sd5);
    else
      rate_trim_ppm_o <= $signed({1'b0, rate_trim_ff[1], rate_trim_ff[0],
        2'b00} * 8'sd5);
  end
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (is_alarm_addr(reg_addr_i))
      nxt_rdata = alarm_ff[alarm_idx(reg_addr_i)];
    else
      case (reg_addr_i)
        `ADDR_STATUS: nxt_rdata = {auto_clear_ff, 4'h0, alarm_flag_ff, 2'b00};
        `ADDR_INT_CTRL: nxt_rdata = int_ctrl_ff;
        `ADDR_LOAD_CAP: nxt_rdata = load_cap_ff;
        `ADDR_RATE_TRIM: nxt_rdata = {5'h00, rate_trim_ff};
        `ADDR_USER0: nxt_rdata = user0_ff;
        `ADDR_USER1: nxt_rdata = user1_ff;
        default: nxt_rdata = 8'h00;
      endcase
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= nxt_rdata;
  end
  a_flag_sets: assert property (alarm_event |=> alarm_flag_ff)
    else $error("flag not set on alarm");
  a_write_clears: assert property (
    (flag_clr && !alarm_event) |=> !alarm_flag_ff)
    else $error("flag not cleared");
  a_held_low: assert property (
    (alarm_event && !pulse_mode) |=> !irq_fout_o)
    else $error("pin not held low");
  a_pin_disabled: assert property (
    (!alarm_en && !fout_sel) |=> irq_fout_o)
    else $error("pin low while disabled");
  a_pulse_low: assert property (
    (alarm_event && pulse_mode) |=> !irq_fout_o [*3])
    else $error("pulse too short");
  a_fout_wins: assert property (fout_sel |=> !$rose(alarm_flag_ff))
    else $error("alarm while freq out");
  a_cap_default: assert property (
    (load_cap_ff == 8'h00 && !bat_sync2_ff) |=> cap_load_qtr_pf_o == `CAP_MID)
    else $error("mid-scale load wrong");
  a_trim_none: assert property (
    (rate_trim_ff == `TRIM_NONE) |=> rate_trim_ppm_o == 8'sh00)
    else $error("code 100 not zero");
  a_once_second: assert property (alarm_event |=> !alarm_event [*2])
    else $error("double trigger");
  c_single: cover property (alarm_event && !pulse_mode);
  c_pulse: cover property (alarm_event && pulse_mode);
  c_autoclr: cover property (flag_clr && auto_clear_ff);
endmodule
